// ---- slbi_pkg.sv ----
`default_nettype none

package slbi_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int PHASE_MS = 250;
   // One blink phase (a pulse or a gap) in clock cycles.
   localparam int PHASE_CYCLES = PHASE_MS * 1000 * CLK_MHZ;
   // Dark pause after a code, counted in phases.
   localparam int PAUSE_PHASES = 6;
   localparam logic [3:0] PAUSE_LAST = 4'(PAUSE_PHASES - 1);

   // ----------------------------------------------------------------
   // Blink category codes
   // ----------------------------------------------------------------
   typedef logic [3:0] slbi_code_t;
   localparam slbi_code_t CODE_OVERTEMP = 4'h1;
   localparam slbi_code_t CODE_OVERLOAD = 4'h2;
   localparam slbi_code_t CODE_COMM = 4'h3;
   localparam slbi_code_t CODE_EXTERNAL = 4'h4;
   localparam slbi_code_t CODE_OVERCURRENT = 4'h5;
   localparam slbi_code_t CODE_VOLTAGE = 4'h6;
   localparam slbi_code_t CODE_OTHER = 4'hA;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_OVERRIDE = 8'h00;
   localparam logic [7:0] ADDR_USER_CMD = 8'h04;
   localparam logic [7:0] ADDR_LED_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam int BIT_YELLOW = 0;
   localparam int BIT_GREEN = 1;
   localparam int BIT_RED = 2;
   localparam int EVT_ALARM = 0;
   localparam int EVT_FAULT = 1;
   localparam int EVT_FORCED = 2;
   localparam logic [2:0] OVERRIDE_RST = 3'h0;
   localparam logic [2:0] USER_CMD_RST = 3'h0;
   localparam logic [2:0] IRQ_STATUS_RST = 3'h0;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic red;
      logic green;
      logic yellow;
   } slbi_leds_t;

   typedef struct packed {
      logic ready;
      logic running;
      logic alarm;
      slbi_code_t alarm_cat;
      logic forced_cfg;
      logic fault;
      slbi_code_t fault_cat;
   } slbi_drive_t;

   typedef enum logic [3:0] {
      BLINK_IDLE = 4'b0001,
      BLINK_ON = 4'b0010,
      BLINK_OFF = 4'b0100,
      BLINK_PAUSE = 4'b1000
   } slbi_blink_state_t;

endpackage : slbi_pkg

`default_nettype wire

// ---- slbi_top.sv ----
// Summary of operation
// - Three outputs: green run, yellow alarm, red fault.
// - Ready, not running: green steady, others dark.
// - Running without alarm or fault: green blinks.
// - Alarm: yellow blinks its category, red dark.
// - Forced power-up configuration, no alarm: yellow blinks code ten.
// - Fault: red blinks category, green and yellow off.
// - Categories one to six; five, six fault only.
// - Anything outside one to six blinks code ten.
// - Status flags mirror present lit state of indicators.
// - User command drives indicator only when overridden.
// - Override bit zero hands yellow to user.
// - Override bit one hands green to user.
// - Override bit two hands red to user.
// - External alarm and fault both use code four.
`timescale 1ns/1ps
`default_nettype none

module slbi_top #(
   parameter int PHASE_CYCLES = slbi_pkg::PHASE_CYCLES
) (
   input wire logic clk, // 200 MHz clock
   input wire logic reset_n, // asynchronous reset, active low
   input wire slbi_pkg::slbi_drive_t drive, // drive state, same clock domain
   input wire logic [7:0] addr, // register byte address
   input wire logic [31:0] wdata, // register write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [31:0] rdata, // read data, cycle after rd
   output slbi_pkg::slbi_leds_t leds, // indicator drive, high is lit
   output logic irq // level interrupt
);
   import slbi_pkg::*;

   // ----------------------------------------------------------------
   // Category mapping
   // ----------------------------------------------------------------
   // Over-current and voltage exist only as faults, so as alarms they
   // fall into the catch-all code.
   function automatic slbi_code_t map_code(input slbi_code_t cat, input logic is_fault);
      slbi_code_t res;
      res = CODE_OTHER;
      if (cat >= CODE_OVERTEMP && cat <= CODE_EXTERNAL)
         res = cat;
      else if (is_fault && (cat == CODE_OVERCURRENT || cat == CODE_VOLTAGE))
         res = cat;
      return res;
   endfunction : map_code

   // ----------------------------------------------------------------
   // Registers and decode
   // ----------------------------------------------------------------
   logic [2:0] indicator_override_select;
   logic [2:0] user_cmd;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [31:0] phase_cnt;
   logic green_blink;
   logic prev_alarm;
   logic prev_fault;
   logic prev_forced;

   wire logic wr_override = wr && addr == ADDR_OVERRIDE;
   wire logic wr_user_cmd = wr && addr == ADDR_USER_CMD;
   wire logic wr_mask = wr && addr == ADDR_IRQ_MASK;
   wire logic rd_irq_status = rd && addr == ADDR_IRQ_STATUS;
   wire logic [31:0] read_mux =
      addr == ADDR_OVERRIDE ? {29'h0, indicator_override_select} :
      addr == ADDR_USER_CMD ? {29'h0, user_cmd} :
      addr == ADDR_LED_STATUS ? {29'h0, leds} :
      addr == ADDR_IRQ_STATUS ? {29'h0, irq_status} :
      addr == ADDR_IRQ_MASK ? {29'h0, irq_mask} : 32'h0;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         indicator_override_select <= OVERRIDE_RST;
         user_cmd <= USER_CMD_RST;
         irq_mask <= IRQ_MASK_RST;
         rdata <= 32'h0;
      end
      else
      begin
         if (wr_override)
            indicator_override_select <= wdata[2:0];
         if (wr_user_cmd)
            user_cmd <= wdata[2:0];
         if (wr_mask)
            irq_mask <= wdata[2:0];
         rdata <= rd ? read_mux : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // Phase timer
   // ----------------------------------------------------------------
   wire logic tick = phase_cnt == 32'(PHASE_CYCLES - 1);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase_cnt <= 32'h0;
         green_blink <= 1'b0;
      end
      else
      begin
         phase_cnt <= tick ? 32'h0 : phase_cnt + 32'h1;
         if (tick)
            green_blink <= !green_blink;
      end
   end

   // ----------------------------------------------------------------
   // Code blinkers: index 0 is yellow, index 1 is red
   // ----------------------------------------------------------------
   wire logic [1:0] want;
   wire slbi_code_t want_code [2];
   wire logic [1:0] lit;

   assign want[0] = !drive.fault && (drive.alarm || drive.forced_cfg);
   assign want_code[0] = drive.alarm ? map_code(drive.alarm_cat, 1'b0) : CODE_OTHER;
   assign want[1] = drive.fault;
   assign want_code[1] = map_code(drive.fault_cat, 1'b1);

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_blink
         slbi_blink_state_t state;
         slbi_blink_state_t next_state;
         slbi_code_t remaining;
         slbi_code_t next_remaining;

         // A pulse and a gap each last one phase; the pause closes the code.
         always_comb
         begin
            next_state = state;
            next_remaining = remaining;
            case (state)
               BLINK_IDLE:
               begin
                  next_state = BLINK_ON;
                  next_remaining = want_code[g];
               end
               BLINK_ON:
                  if (tick)
                  begin
                     next_state = BLINK_OFF;
                     next_remaining = remaining - 4'h1;
                  end
               BLINK_OFF:
                  if (tick)
                  begin
                     next_state = remaining == 4'h0 ? BLINK_PAUSE : BLINK_ON;
                     next_remaining = remaining == 4'h0 ? PAUSE_LAST : remaining;
                  end
               BLINK_PAUSE:
                  if (tick)
                  begin
                     next_state = remaining == 4'h0 ? BLINK_IDLE : BLINK_PAUSE;
                     next_remaining = remaining - 4'h1;
                  end
               default:
                  next_state = BLINK_IDLE;
            endcase
            if (!want[g])
               next_state = BLINK_IDLE;
         end

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               state <= BLINK_IDLE;
               remaining <= 4'h0;
            end
            else
            begin
               state <= next_state;
               remaining <= next_remaining;
            end
         end

         // Lit follows the next state, so a fault or a dropped cause darkens
         // the indicator in the same cycle as the steady logic reacts.
         assign lit[g] = next_state == BLINK_ON;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Indicator selection and interrupts
   // ----------------------------------------------------------------
   wire logic auto_green =
      !drive.fault && (drive.running ? green_blink : drive.ready);
   wire slbi_leds_t auto_leds = '{red: lit[1], green: auto_green, yellow: lit[0]};
   wire slbi_leds_t next_leds = (auto_leds & ~indicator_override_select)
      | (user_cmd & indicator_override_select);
   wire logic [2:0] events = {
      drive.forced_cfg && !prev_forced,
      drive.fault && !prev_fault,
      drive.alarm && !prev_alarm
   };

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         leds <= '0;
         irq_status <= IRQ_STATUS_RST;
         irq <= 1'b0;
         prev_alarm <= 1'b0;
         prev_fault <= 1'b0;
         prev_forced <= 1'b0;
      end
      else
      begin
         leds <= next_leds;
         prev_alarm <= drive.alarm;
         prev_fault <= drive.fault;
         prev_forced <= drive.forced_cfg;
         // A new event in the clearing read cycle survives the clear.
         irq_status <= (rd_irq_status ? 3'h0 : irq_status) | events;
         irq <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_fault_darkens_others: assert property (
      drive.fault && indicator_override_select == 3'h0 |=> !leds.green && !leds.yellow)
      else $error("green or yellow lit during fault");
   chk_ready_green_steady: assert property (
      drive.ready && !drive.running && !drive.fault && !drive.alarm && !drive.forced_cfg
      && indicator_override_select == 3'h0 |=> leds.green && !leds.red && !leds.yellow)
      else $error("ready state not shown as steady green");
   chk_running_green_toggles: assert property (
      tick && drive.running && !drive.fault && !indicator_override_select[BIT_GREEN]
      ##1 drive.running && !drive.fault && !indicator_override_select[BIT_GREEN]
      |=> leds.green != $past(leds.green))
      else $error("green did not follow the blink phase while running");
   chk_user_override: assert property (
      1'b1 |=> (leds & $past(indicator_override_select)) ==
      ($past(user_cmd) & $past(indicator_override_select)))
      else $error("overridden indicator does not follow user command");
   chk_auto_when_free: assert property (
      !indicator_override_select[BIT_RED] |=> leds.red == $past(lit[1]))
      else $error("red not driven by its own blinker");
   chk_status_mirror: assert property (
      rd && addr == ADDR_LED_STATUS |=> rdata[2:0] == $past(leds))
      else $error("status flags differ from indicators");
   chk_code_latch: assert property (
      g_blink[1].state == BLINK_IDLE && want[1] |=>
      g_blink[1].state == BLINK_ON && g_blink[1].remaining == $past(want_code[1]))
      else $error("red code not latched at start of sequence");
   chk_forced_code_ten: assert property (
      g_blink[0].state == BLINK_IDLE && want[0] && !drive.alarm |=>
      g_blink[0].remaining == CODE_OTHER)
      else $error("forced configuration not shown as code ten");
   chk_alarm_voltage_other: assert property (
      drive.alarm && (drive.alarm_cat == CODE_VOLTAGE || drive.alarm_cat == 4'h9)
      |-> want_code[0] == CODE_OTHER)
      else $error("alarm category outside table not mapped to ten");
   chk_irq_read_clear: assert property (
      rd_irq_status && events == 3'h0 |=> irq_status == 3'h0)
      else $error("status not cleared by read");
   chk_irq_set_wins: assert property (
      rd_irq_status && events != 3'h0 |=> (irq_status & $past(events)) == $past(events))
      else $error("event lost in clearing read");
   chk_irq_level: assert property (
      1'b1 |=> irq == |($past(irq_status) & $past(irq_mask)))
      else $error("interrupt level does not follow unmasked status");
   chk_rdata_idle: assert property (
      !rd |=> rdata == 32'h0)
      else $error("read data not zero outside read answer");
   chk_alarm_red_dark: assert property (
      !drive.fault && !indicator_override_select[BIT_RED] |=> !leds.red)
      else $error("red lit without fault");
   chk_yellow_free: assert property (
      !indicator_override_select[BIT_YELLOW] |=> leds.yellow == $past(lit[0]))
      else $error("yellow not driven by its own blinker");
   chk_override_write: assert property (
      wr_override |=> indicator_override_select == $past(wdata[2:0]))
      else $error("override setting not written");
   chk_blink_idle: assert property (
      !want[1] |=> g_blink[1].state == BLINK_IDLE)
      else $error("red blinker not idle without cause");

   cov_fault_blink: cover property (g_blink[1].state == BLINK_PAUSE);
   cov_alarm_blink: cover property (g_blink[0].state == BLINK_ON && drive.alarm);
   cov_override_all: cover property (indicator_override_select == 3'h7 && leds == 3'h7);
   cov_irq_raised: cover property (irq);
   cov_forced_blink: cover property (g_blink[0].state == BLINK_ON && drive.forced_cfg && !drive.alarm);

endmodule : slbi_top

`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import slbi_pkg::*;
   localparam int PH = 4;
   logic clk;
   logic reset_n;
   slbi_drive_t drive;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   slbi_leds_t leds;
   logic irq;
   int err_total;
   int check_count;
   int cyc;
   logic [31:0] r;

   slbi_top #(.PHASE_CYCLES(PH)) DUT (.clk(clk), .reset_n(reset_n), .drive(drive), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .leds(leds), .irq(irq));

   // ----------------------------------------------------------------
   // Clock, reset and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         err_total = err_total + 1;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count = check_count + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic set_drive(input slbi_drive_t v);
      @(posedge clk);
      drive <= v;
      repeat (3) @(posedge clk);
      #1;
   endtask : set_drive

   // Counts the pulses of one indicator between two long dark pauses.
   task automatic count_code(input int idx, input logic [2:0] dark, input int n_exp,
      input string nm);
      int run;
      int n;
      int t;
      logic prev;
      logic [2:0] bad;
      run = 0;
      t = 0;
      bad = '0;
      while (run < 16 && t < 600)
      begin
         @(posedge clk);
         #1;
         t++;
         run = leds[idx] ? 0 : run + 1;
      end
      while (leds[idx] !== 1'b1 && t < 700)
      begin
         @(posedge clk);
         #1;
         t++;
      end
      n = 0;
      run = 0;
      prev = 1'b0;
      while (run < 16 && t < 1400)
      begin
         if (leds[idx] === 1'b1 && !prev)
            n++;
         prev = leds[idx];
         run = leds[idx] ? 0 : run + 1;
         bad = bad | (leds & dark);
         @(posedge clk);
         #1;
         t++;
      end
      chk(nm, 32'(n_exp), 32'(n));
      chk("dark leds", 32'h0, {29'h0, bad});
   endtask : count_code

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk("leds at reset", 32'h0, {29'h0, leds});
      rd_reg(ADDR_OVERRIDE, r);
      chk("override reset", 32'h0, r);
      rd_reg(ADDR_USER_CMD, r);
      chk("user cmd reset", 32'h0, r);
      rd_reg(ADDR_IRQ_MASK, r);
      chk("mask reset", 32'h0, r);
      rd_reg(8'h14, r);
      chk("unmapped", 32'h0, r);
      $display("test reset done");
   endtask : t_reset

   task automatic t_ready_run();
      int tog;
      logic [2:0] bad;
      set_drive({1'b1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 4'h0});
      repeat (40)
      begin
         @(posedge clk);
         #1;
         chk("ready leds", 32'h2, {29'h0, leds});
      end
      set_drive({1'b1, 1'b1, 1'b0, 4'h0, 1'b0, 1'b0, 4'h0});
      tog = 0;
      bad = '0;
      r[0] = leds.green;
      repeat (40)
      begin
         @(posedge clk);
         #1;
         if (leds.green !== r[0])
            tog++;
         r[0] = leds.green;
         bad = bad | {leds.red, 1'b0, leds.yellow};
      end
      chk("run toggles", 32'h1, 32'(tog >= 8 && tog <= 11));
      chk("run dark", 32'h0, {29'h0, bad});
      $display("test ready and run done");
   endtask : t_ready_run

   task automatic t_codes();
      int e;
      for (int c = 0; c < 10; c++)
      begin
         e = (c >= 1 && c <= 4) ? c : 10;
         set_drive({1'b1, 1'b1, 1'b1, 4'(c), 1'b0, 1'b0, 4'h0});
         count_code(0, 3'b100, e, "alarm code");
         set_drive('0);
      end
      set_drive({1'b1, 1'b1, 1'b0, 4'h0, 1'b1, 1'b0, 4'h0});
      count_code(0, 3'b100, 10, "forced code");
      for (int c = 1; c < 9; c += 1)
      begin
         e = (c <= 6) ? c : 10;
         set_drive({1'b1, 1'b0, 1'b1, 4'h2, 1'b0, 1'b1, 4'(c)});
         count_code(2, 3'b011, e, "fault code");
         set_drive('0);
      end
      $display("test codes done");
   endtask : t_codes

   task automatic t_override();
      for (int b = 0; b < 3; b++)
      begin
         wr_reg(ADDR_OVERRIDE, 32'h1 << b);
         wr_reg(ADDR_USER_CMD, 32'h7);
         repeat (3) @(posedge clk);
         #1;
         chk("override bit", 32'h1 << b, {29'h0, leds});
      end
      wr_reg(ADDR_OVERRIDE, 32'hFFFF_FFFF);
      rd_reg(ADDR_OVERRIDE, r);
      chk("override width", 32'h7, r);
      wr_reg(ADDR_USER_CMD, 32'h5);
      set_drive({1'b1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 4'h0});
      chk("user leds", 32'h5, {29'h0, leds});
      rd_reg(ADDR_LED_STATUS, r);
      chk("status flags", 32'h5, r);
      wr_reg(ADDR_OVERRIDE, 32'h0);
      repeat (3) @(posedge clk);
      #1;
      chk("auto again", 32'h2, {29'h0, leds});
      rd_reg(ADDR_LED_STATUS, r);
      chk("status auto", 32'h2, r);
      $display("test override done");
   endtask : t_override

   task automatic t_irq();
      set_drive('0);
      rd_reg(ADDR_IRQ_STATUS, r);
      set_drive({1'b0, 1'b0, 1'b1, 4'h1, 1'b0, 1'b0, 4'h0});
      chk("masked irq", 32'h0, {31'h0, irq});
      rd_reg(ADDR_IRQ_STATUS, r);
      chk("alarm event", 32'h1, r);
      wr_reg(ADDR_IRQ_MASK, 32'h7);
      set_drive({1'b0, 1'b0, 1'b0, 4'h0, 1'b1, 1'b1, 4'h1});
      chk("irq raised", 32'h1, {31'h0, irq});
      rd_reg(ADDR_IRQ_STATUS, r);
      chk("fault event", 32'h6, r);
      repeat (3) @(posedge clk);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      // An alarm edge in the clearing read cycle must stay pending.
      @(posedge clk);
      addr <= ADDR_IRQ_STATUS;
      rd <= 1'b1;
      drive <= {1'b0, 1'b0, 1'b1, 4'h1, 1'b1, 1'b1, 4'h1};
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("clearing read", 32'h0, rdata);
      rd_reg(ADDR_IRQ_STATUS, r);
      chk("set wins", 32'h1, r);
      $display("test interrupt done");
   endtask : t_irq

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      err_total = 0;
      check_count = 0;
      cyc = 0;
      reset_n = 1'b0;
      drive = '0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_ready_run();
      t_codes();
      t_override();
      t_irq();
      test_done();
   end
endmodule : tb_top

`default_nettype wire
